// ### core/address_breakpoint_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "break_unit_defs.svh"
// What this block does
// R01: Enabled address match requests a software interrupt
// R02: Vector FFFC normally, FEFC in monitor mode
// R03: Writing one to active flag forces break
// R04: Opcode match breaks before that instruction runs
// R05: Operand match lets instruction finish first
// R06: Match sets active flag; write zero clears
// R07: Enable bit seven gates full address match
// R08: Break address in high and low bytes
// R09: Return from interrupt ends the break state
// R10: Timer counter halted while break in progress
// R11: Watchdog held in break with monitor mode
// R12: Status clears in break only when enabled
// R13: In emulation mode, flag records wait exit caused by break
// R14: No address break in wait or stop
// R15: Same address no rebreak until address rewritten
// R16: Software rewrites address, clears flag, each break
// R17: Compare program counter fetches, every clock cycle
module address_breakpoint_unit
  import break_unit_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  // AXI4-Lite read data
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // CPU core and chip mode
  input  wire cpu_bus_t    cpu_i,
  input  wire sys_mode_t   mode_i,
  // To system integration logic and peripherals
  output logic             breakpoint_request_o,
  output logic [15:0]      break_vector_o,
  output logic             break_state_o,
  output logic             timer_halt_o,
  output logic             watchdog_hold_o,
  output logic             flag_clear_allow_o
);

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  logic rstn_s;
  assign rstn_s = rst_sync_reg;

  // Bus slave state
  logic        aw_have_reg, aw_have_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic        w_have_reg, w_have_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  // Break registers
  logic         enable_reg, enable_next;
  logic         active_reg, active_next;
  logic [7:0]   addr_high_reg, addr_high_next;
  logic [7:0]   addr_low_reg, addr_low_next;
  logic         wdog_hold_reg, wdog_hold_next;
  logic         wait_exit_reg, wait_exit_next;
  logic         flag_clear_reg, flag_clear_next;
  logic         hold_off_reg, hold_off_next;
  break_phase_t phase_reg, phase_next;
  logic [15:0]  vector_reg, vector_next;

  // Write decode
  logic       do_write;
  logic       lane0;
  logic [7:0] wbyte;
  logic       wr_status, wr_high, wr_low, wr_aux, wr_wait, wr_flag;
  logic       wr_mapped;

  assign do_write  = aw_have_reg && w_have_reg && !bvalid_reg;
  assign lane0     = wstrb_reg[0];
  assign wbyte     = wdata_reg[7:0];
  assign wr_status = do_write && lane0
                     && (awaddr_reg == `BRK_OFS_STATUS_CONTROL);
  assign wr_high   = do_write && lane0
                     && (awaddr_reg == `BRK_OFS_ADDRESS_HIGH);
  assign wr_low    = do_write && lane0
                     && (awaddr_reg == `BRK_OFS_ADDRESS_LOW);
  assign wr_aux    = do_write && lane0
                     && (awaddr_reg == `BRK_OFS_AUXILIARY);
  assign wr_wait   = do_write && lane0
                     && (awaddr_reg == `BRK_OFS_WAIT_STATUS);
  assign wr_flag   = do_write && lane0
                     && (awaddr_reg == `BRK_OFS_FLAG_CONTROL);

  // Address map check for the response code
  always_comb begin
    unique case (awaddr_reg)
      `BRK_OFS_STATUS_CONTROL, `BRK_OFS_ADDRESS_HIGH,
      `BRK_OFS_ADDRESS_LOW, `BRK_OFS_AUXILIARY,
      `BRK_OFS_WAIT_STATUS, `BRK_OFS_FLAG_CONTROL: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Break triggers
  logic trig_hw;
  logic sw_force;
  logic req_now;

  assign trig_hw = enable_reg                                  // see R07
                   && cpu_i.fetch                              // see R17
                   && (cpu_i.addr == {addr_high_reg, addr_low_reg}) // see R08
                   && !active_reg && !hold_off_reg             // see R15
                   && !mode_i.wait_mode && !mode_i.stop_mode;  // see R14
  assign sw_force = wr_status && wbyte[`BRK_BIT_ACTIVE];       // see R03

  // Request at instruction boundary; opcode hit goes straight through
  assign req_now = cpu_i.boundary
                   && ((phase_reg == PHASE_PENDING)            // see R05
                       || ((phase_reg == PHASE_IDLE)
                           && trig_hw && cpu_i.opcode));       // see R04

  // Read data mux
  logic [7:0] rbyte;
  logic       rd_mapped;
  always_comb begin
    rbyte     = `BRK_RST_BYTE;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr_i)
      `BRK_OFS_STATUS_CONTROL: begin
        rbyte[`BRK_BIT_ENABLE] = enable_reg;
        rbyte[`BRK_BIT_ACTIVE] = active_reg;
      end
      `BRK_OFS_ADDRESS_HIGH: rbyte = addr_high_reg;
      `BRK_OFS_ADDRESS_LOW:  rbyte = addr_low_reg;
      `BRK_OFS_AUXILIARY:    rbyte[`BRK_BIT_WDOG_HOLD] = wdog_hold_reg;
      `BRK_OFS_WAIT_STATUS:  rbyte[`BRK_BIT_WAIT_EXIT] = wait_exit_reg;
      `BRK_OFS_FLAG_CONTROL: rbyte[`BRK_BIT_FLAG_CLEAR] = flag_clear_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Bus slave next state
  always_comb begin
    aw_have_next = aw_have_reg;
    awaddr_next  = awaddr_reg;
    w_have_next  = w_have_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata_i;
      wstrb_next  = s_axi_wstrb_i;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_mapped ? `BRK_RESP_OKAY : `BRK_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rdata_next  = {24'h000000, rbyte};
      rresp_next  = rd_mapped ? `BRK_RESP_OKAY : `BRK_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
  end

  // Bus slave registers
  always_ff @(posedge clock_i or negedge rstn_s) begin
    if (!rstn_s) begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_have_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `BRK_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `BRK_RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      awaddr_reg  <= awaddr_next;
      w_have_reg  <= w_have_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Break register and sequencer next state
  always_comb begin
    enable_next     = enable_reg;
    active_next     = active_reg;
    addr_high_next  = addr_high_reg;
    addr_low_next   = addr_low_reg;
    wdog_hold_next  = wdog_hold_reg;
    wait_exit_next  = wait_exit_reg;
    flag_clear_next = flag_clear_reg;
    hold_off_next   = hold_off_reg;
    phase_next      = phase_reg;
    // Control writes
    if (wr_status) begin
      enable_next = wbyte[`BRK_BIT_ENABLE];               // see R07
      active_next = wbyte[`BRK_BIT_ACTIVE];               // see R06
    end
    if (wr_high) begin
      addr_high_next = wbyte;                             // see R08
    end
    if (wr_low) begin
      addr_low_next = wbyte;                              // see R08
    end
    if (wr_aux) begin
      wdog_hold_next = wbyte[`BRK_BIT_WDOG_HOLD];         // see R11
    end
    if (wr_flag) begin
      flag_clear_next = wbyte[`BRK_BIT_FLAG_CLEAR];       // see R12
    end
    // Rewriting the address re-arms matching
    if (wr_high || wr_low) begin
      hold_off_next = 1'b0;                               // see R15
    end
    // Hardware set wins over a software clear
    if (trig_hw) begin
      active_next   = 1'b1;                               // see R06
      hold_off_next = 1'b1;                               // see R15
    end
    // Wait exit flag: write zero clears, break exit in emulation mode sets
    if (wr_wait && !wbyte[`BRK_BIT_WAIT_EXIT]) begin
      wait_exit_next = 1'b0;
    end
    if (mode_i.wait_exit && mode_i.emulation
        && (phase_reg != PHASE_IDLE || req_now)) begin
      wait_exit_next = 1'b1;                              // see R13
    end
    // Sequencer
    unique case (phase_reg)
      PHASE_IDLE: begin
        if (req_now) begin
          phase_next = PHASE_IN_BREAK;                    // see R04
        end else if (trig_hw || sw_force) begin
          phase_next = PHASE_PENDING;                     // see R05
        end
      end
      PHASE_PENDING: begin
        if (req_now) begin
          phase_next = PHASE_IN_BREAK;                    // see R03
        end
      end
      PHASE_IN_BREAK: begin
        if (cpu_i.return_from_interrupt_instruction) begin
          phase_next = PHASE_IDLE;                        // see R09
        end
      end
      default: phase_next = PHASE_IDLE;
    endcase
  end

  // Vector choice follows monitor mode
  assign vector_next = mode_i.monitor ? `BRK_VECTOR_MONITOR
                                      : `BRK_VECTOR_NORMAL; // see R02

  // Break registers
  always_ff @(posedge clock_i or negedge rstn_s) begin
    if (!rstn_s) begin
      enable_reg     <= 1'b0;
      active_reg     <= 1'b0;
      addr_high_reg  <= `BRK_RST_BYTE;
      addr_low_reg   <= `BRK_RST_BYTE;
      wdog_hold_reg  <= 1'b0;
      wait_exit_reg  <= 1'b0;
      flag_clear_reg <= 1'b0;
      hold_off_reg   <= 1'b0;
      phase_reg      <= PHASE_IDLE;
      vector_reg     <= `BRK_VECTOR_NORMAL;
    end else begin
      enable_reg     <= enable_next;
      active_reg     <= active_next;
      addr_high_reg  <= addr_high_next;
      addr_low_reg   <= addr_low_next;
      wdog_hold_reg  <= wdog_hold_next;
      wait_exit_reg  <= wait_exit_next;
      flag_clear_reg <= flag_clear_next;
      hold_off_reg   <= hold_off_next;
      phase_reg      <= phase_next;
      vector_reg     <= vector_next;
    end
  end

  // Bus outputs
  assign s_axi_awready_o = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // Break side outputs
  logic in_break;
  assign in_break             = (phase_reg == PHASE_IN_BREAK);
  assign breakpoint_request_o = req_now;                   // see R01
  assign break_vector_o       = vector_reg;                // see R02
  assign break_state_o        = in_break;
  assign timer_halt_o         = in_break;                  // see R10
  assign watchdog_hold_o      = in_break && mode_i.monitor
                                && wdog_hold_reg;          // see R11
  assign flag_clear_allow_o   = !in_break || flag_clear_reg; // see R12

endmodule // address_breakpoint_unit
`default_nettype wire

// ### core/break_unit_defs.svh
`ifndef BREAK_UNIT_DEFS_SVH
`define BREAK_UNIT_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define BRK_OFS_STATUS_CONTROL  8'h00
`define BRK_OFS_ADDRESS_HIGH    8'h04
`define BRK_OFS_ADDRESS_LOW     8'h08
`define BRK_OFS_AUXILIARY       8'h0C
`define BRK_OFS_WAIT_STATUS     8'h10
`define BRK_OFS_FLAG_CONTROL    8'h14

// Field positions
`define BRK_BIT_ENABLE          7
`define BRK_BIT_ACTIVE          6
`define BRK_BIT_WDOG_HOLD       0
`define BRK_BIT_WAIT_EXIT       1
`define BRK_BIT_FLAG_CLEAR      7

// Reset values
`define BRK_RST_BYTE            8'h00

// Break vectors
`define BRK_VECTOR_NORMAL       16'hFFFC
`define BRK_VECTOR_MONITOR      16'hFEFC

// AXI responses
`define BRK_RESP_OKAY           2'h0
`define BRK_RESP_SLVERR         2'h2

`endif

// ### core/break_unit_pkg.sv
package break_unit_pkg;

  // Break sequencing, one-hot
  typedef enum logic [2:0] {
    PHASE_IDLE     = 3'b001,
    PHASE_PENDING  = 3'b010,
    PHASE_IN_BREAK = 3'b100
  } break_phase_t;

  // CPU core side, same clock
  typedef struct packed {
    logic [15:0] addr;      // Address on the internal bus
    logic        fetch;     // Address comes from the program counter
    logic        opcode;    // This fetch is an opcode fetch
    logic        boundary;  // Next instruction about to start
    logic        return_from_interrupt_instruction;       // Return from interrupt executed
  } cpu_bus_t;

  // Chip mode from system integration logic, same clock
  typedef struct packed {
    logic monitor;    // Monitor mode
    logic emulation;  // Emulation mode
    logic wait_mode;  // In wait mode
    logic stop_mode;  // In stop mode
    logic wait_exit;  // Pulse: wait mode left
  } sys_mode_t;

endpackage

// ### verif/break_checker.sv
`timescale 1ns/1ns
`default_nettype none
module break_checker
  import break_unit_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire cpu_bus_t    cpu_i,
  input wire sys_mode_t   mode_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        breakpoint_request_o,
  input wire logic [15:0] break_vector_o,
  input wire logic        break_state_o,
  input wire logic        timer_halt_o,
  input wire logic        watchdog_hold_o,
  input wire logic        flag_clear_allow_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // Request, break entry and exit
  chk_req_boundary: assert property (
    breakpoint_request_o |-> cpu_i.boundary)
    else $error("request outside a boundary cycle");
  chk_req_enters: assert property (
    breakpoint_request_o |=> break_state_o)
    else $error("request did not enter break");
  chk_rti_ends: assert property (
    break_state_o && cpu_i.return_from_interrupt_instruction |=> !break_state_o)
    else $error("return did not end break");
  chk_break_holds: assert property (
    break_state_o && !cpu_i.return_from_interrupt_instruction |=> break_state_o)
    else $error("break ended without return");
  // Outputs derived from break state and monitor mode, and read data hold
  chk_timer_halt: assert property (
    timer_halt_o == break_state_o)
    else $error("timer halt differs from break state");
  chk_wdog_hold: assert property (
    watchdog_hold_o |-> break_state_o && mode_i.monitor)
    else $error("watchdog held outside monitor break");
  chk_flag_allow: assert property (
    !break_state_o |-> flag_clear_allow_o)
    else $error("flag clearing blocked outside break");
  chk_vector_mode: assert property (
    $past(rstn_i, 4) |-> break_vector_o ==
      ($past(mode_i.monitor) ? 16'hFEFC : 16'hFFFC))
    else $error("wrong break vector");
  chk_read_stands: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped early");
  // Main scenarios reached
  cov_request: cover property (breakpoint_request_o);
  cov_exit: cover property (break_state_o ##1 !break_state_o);
  cov_wdog: cover property (watchdog_hold_o);
endmodule // break_checker
`default_nettype wire

// ### verif/cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_model
  import break_unit_pkg::*;
(
  // Clock, reset and bench commands
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        start_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        rti_i,
  // Bus activity toward the break unit
  output var cpu_bus_t     cpu_o
);
  logic [1:0]  step_reg, step_next;
  logic [15:0] last_reg, last_next;

  // Opcode, operand, next opcode, then idle
  always_comb begin
    cpu_o.fetch = step_reg != 2'h0;
    cpu_o.opcode = step_reg[0];
    cpu_o.boundary = step_reg[0];
    cpu_o.return_from_interrupt_instruction = rti_i;
    cpu_o.addr = cpu_o.fetch ? pc_i + 16'(step_reg) - 16'h1 : ~last_reg;
    step_next = start_i ? 2'h1 : step_reg + {1'h0, cpu_o.fetch};
    last_next = cpu_o.addr;  // Idle address keeps changing
  end

  // Step and address registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_reg <= 2'h0;
      last_reg <= 16'h0;
    end else begin
      step_reg <= step_next;
      last_reg <= last_next;
    end
  end
endmodule // cpu_model
`default_nettype wire

// ### verif/tb_address_breakpoint_unit.sv
`timescale 1ns/1ns
`default_nettype none
module tb_address_breakpoint_unit
  import break_unit_pkg::*;
;
  logic        clock_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, start = 1'h0, return_from_interrupt_instruction = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] pc = 16'h0, req_addr, vector;
  logic        req, in_brk, halt, wdog, allow;
  cpu_bus_t    cpu;
  sys_mode_t   mode = '0;
  int          mismatches = 0, check_count = 0, reqs = 0, cyc = 0;

  always #25 clock_i = ~clock_i;

  address_breakpoint_unit dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .cpu_i(cpu), .mode_i(mode),
    .breakpoint_request_o(req), .break_vector_o(vector),
    .break_state_o(in_brk), .timer_halt_o(halt),
    .watchdog_hold_o(wdog), .flag_clear_allow_o(allow));

  cpu_model partner (.clock_i(clock_i), .rstn_i(rstn_i), .start_i(start),
    .pc_i(pc), .rti_i(return_from_interrupt_instruction), .cpu_o(cpu));

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clock_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'h1;
    do @(posedge clock_i); while (!bvalid);
    bready <= 1'h0;
    cmp(32'(bresp), 32'h0);
  endtask

  // Register read, answer accepted one cycle late
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'h0;
    @(posedge clock_i);
    rready <= 1'h1;
    do @(posedge clock_i); while (!rvalid);
    rready <= 1'h0;
    cmp(rdata, {24'h0, e});
    cmp(32'(rresp), 32'(er));
  endtask

  // One opcode, operand, opcode run on the partner
  task automatic run(input logic [15:0] p);
    pc <= p;
    start <= 1'h1;
    @(posedge clock_i);
    start <= 1'h0;
    repeat (5) @(posedge clock_i);
  endtask

  // Clear active flag, then return from the routine
  task automatic brk_end();
    wr(8'h00, 8'h80);
    return_from_interrupt_instruction <= 1'h1;
    @(posedge clock_i);
    return_from_interrupt_instruction <= 1'h0;
    @(posedge clock_i);
  endtask

  // Request tally and hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (req) begin
      reqs++;
      req_addr <= cpu.addr;
    end
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 8'h00);
    rd(8'h18, 8'h00, 2'h2);
    wr(8'h04, 8'h12);
    wr(8'h08, 8'h34);
    rd(8'h04, 8'h12);
    rd(8'h08, 8'h34);
    wr(8'h00, 8'h80);
    run(16'h1234);
    cmp(reqs, 1);
    cmp(req_addr, 16'h1234);
    cmp(halt, 1'h1);
    cmp(vector, 16'hFFFC);
    rd(8'h00, 8'hC0);
    mode.monitor <= 1'h1;
    wr(8'h0C, 8'h01);
    cmp(wdog, 1'h1);
    cmp(vector, 16'hFEFC);
    cmp(allow, 1'h0);
    wr(8'h14, 8'h80);
    cmp(allow, 1'h1);
    brk_end();
    mode.monitor <= 1'h0;
    cmp(in_brk, 1'h0);
    run(16'h1234);
    cmp(reqs, 1);
    wr(8'h08, 8'h35);
    run(16'h1234);
    cmp(reqs, 2);
    cmp(req_addr, 16'h1236);
    brk_end();
    wr(8'h00, 8'hC0);
    run(16'h1000);
    cmp(req_addr, 16'h1000);
    brk_end();
    wr(8'h08, 8'h40);
    mode.wait_mode <= 1'h1;
    run(16'h1240);
    mode.wait_mode <= 1'h0;
    mode.stop_mode <= 1'h1;
    run(16'h1240);
    mode.stop_mode <= 1'h0;
    cmp(reqs, 3);
    rd(8'h00, 8'h80);
    run(16'h1240);
    cmp(reqs, 4);
    cmp(req_addr, 16'h1240);
    brk_end();
    wr(8'h08, 8'h40);
    wr(8'h00, 8'h00);
    run(16'h1240);
    cmp(reqs, 4);
    mode.emulation <= 1'h1;
    wr(8'h00, 8'hC0);
    mode.wait_exit <= 1'h1;
    @(posedge clock_i);
    mode.wait_exit <= 1'h0;
    rd(8'h10, 8'h02);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h00);
    close_out();
  end
endmodule // tb_address_breakpoint_unit

bind address_breakpoint_unit break_checker chk (.clock_i(clock_i),
  .rstn_i(rstn_i), .cpu_i(cpu_i), .mode_i(mode_i),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o),
  .breakpoint_request_o(breakpoint_request_o),
  .break_vector_o(break_vector_o), .break_state_o(break_state_o),
  .timer_halt_o(timer_halt_o), .watchdog_hold_o(watchdog_hold_o),
  .flag_clear_allow_o(flag_clear_allow_o));
`default_nettype wire
